//--- src/dws_pkg.sv
// shared constants and types for the dual wiper serial controller
package dws_pkg;

  // clock and timing
  localparam int CLK_MHZ = 125;
  localparam int NV_WRITE_MS = 5;
  localparam int NV_WRITE_CYC = NV_WRITE_MS * 1000 * CLK_MHZ;
  localparam int LOAD_SETTLE_US = 10;
  localparam int LOAD_SETTLE_CYC = LOAD_SETTLE_US * CLK_MHZ;
  localparam int STEP_SETTLE_US = 5;
  localparam int STEP_SETTLE_CYC = STEP_SETTLE_US * CLK_MHZ;
  // host side only: wait after supply is stable
  localparam int POWERUP_READ_MS = 1;
  localparam int POWERUP_WRITE_MS = 1;

  // geometry
  localparam int N_POTS = 2;
  localparam int N_SLOTS = 4;
  localparam int WIPER_W = 6;
  localparam int N_TAPS = 64;
  localparam int SLOT_W = 2;
  localparam int NV_AW = 3;

  // arbitrary type code, not taken from any part
  localparam logic [3:0] TYPE_CODE_DEF = 4'hA;

  // byte field positions
  localparam int TYPE_MSB = 7;
  localparam int TYPE_LSB = 4;
  localparam int ADDR_MSB = 1;
  localparam int ADDR_LSB = 0;
  localparam int OP_MSB = 7;
  localparam int OP_LSB = 4;
  localparam int SLOT_SEL_HI = 3;
  localparam int SLOT_SEL_LO = 2;
  localparam int POT_BIT = 0;
  localparam int PEND_BIT = 0;

  // opcodes
  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'hA;
  localparam logic [3:0] OP_RD_SLOT = 4'hB;
  localparam logic [3:0] OP_WR_SLOT = 4'hC;
  localparam logic [3:0] OP_SLOT_TO_WIPER = 4'hD;
  localparam logic [3:0] OP_WIPER_TO_SLOT = 4'hE;
  localparam logic [3:0] OP_ALL_SLOT_TO_WIPER = 4'h1;
  localparam logic [3:0] OP_ALL_WIPER_TO_SLOT = 4'h8;
  localparam logic [3:0] OP_STEP = 4'h2;
  localparam logic [3:0] OP_RD_STATUS = 4'h5;

  // reset and limit values
  localparam logic [WIPER_W-1:0] WIPER_RST = 6'h00;
  localparam logic [WIPER_W-1:0] WIPER_MAX = 6'h3F;
  localparam logic [WIPER_W-1:0] WIPER_ONE = 6'h01;
  localparam logic [N_TAPS-1:0] TAP_ONE = 64'h0000000000000001;
  localparam logic [WIPER_W-1:0] NV_INIT_DEF = 6'h20;

  typedef enum logic [2:0] {
    ST_BOOT, ST_ADDR, ST_INSTR, ST_DATA, ST_STEP, ST_SKIP
  } dws_state_t;

endpackage

//--- src/dws_link_if.sv
// byte level link between serial front end and command logic
`timescale 1ns/10ps
interface dws_link_if;
  logic byte_vld;
  logic [7:0] byte_data;
  logic sck_rise;
  logic si_lvl;
  logic frame_end;
  logic sel;
  logic tx_load;
  logic [7:0] tx_byte;

  modport rx (
    output byte_vld, byte_data, sck_rise, si_lvl, frame_end, sel,
    input tx_load, tx_byte
  );
  modport ctl (
    input byte_vld, byte_data, sck_rise, si_lvl, frame_end, sel,
    output tx_load, tx_byte
  );
endinterface

//--- src/dws_spi_rx.sv
// serial front end: pin sync, byte assembly, read data shifter
`timescale 1ns/10ps
module dws_spi_rx
  import dws_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  dws_link_if.rx lnk
);

  // order {sck, cs_n, si}; only sync_r and later stages are read
  logic [2:0] meta_r, sync_r, dly_r;
  logic [2:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt;
  logic so_r, so_nxt, oe_r, oe_nxt;
  logic fall;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= 3'h2;
      sync_r <= 3'h2;
      dly_r <= 3'h2;
    end else begin
      meta_r <= {sck, cs_n, si};
      sync_r <= meta_r;
      dly_r <= sync_r;
    end
  end

  assign lnk.sel = ~sync_r[1];
  assign lnk.si_lvl = sync_r[0];
  assign lnk.sck_rise = sync_r[2] & ~dly_r[2] & lnk.sel;
  assign fall = ~sync_r[2] & dly_r[2] & lnk.sel;
  assign lnk.frame_end = sync_r[1] & ~dly_r[1];
  assign lnk.byte_vld = lnk.sck_rise && (cnt_r == 3'h7);
  assign lnk.byte_data = {sh_r[6:0], sync_r[0]};
  assign so = so_r;
  assign so_oe = oe_r;

  always_comb begin
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    tx_nxt = tx_r;
    so_nxt = so_r;
    oe_nxt = oe_r;
    if (!lnk.sel) begin
      // partial byte dropped on deselect
      cnt_nxt = 3'h0;
      oe_nxt = 1'b0;
      so_nxt = 1'b0;
    end else begin
      if (lnk.sck_rise) begin
        cnt_nxt = cnt_r + 3'h1;
        sh_nxt = lnk.byte_data;
      end
      // mode 0: next bit goes out on the falling edge
      if (fall) begin
        so_nxt = tx_r[7];
        tx_nxt = {tx_r[6:0], 1'b0};
      end
      if (lnk.tx_load) begin
        tx_nxt = lnk.tx_byte;
        oe_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 3'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      so_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
      so_r <= so_nxt;
      oe_r <= oe_nxt;
    end
  end

endmodule

//--- src/dws_nv_store.sv
// saved setting store with timed programming cycle
`timescale 1ns/10ps
module dws_nv_store
  import dws_pkg::*;
#(
  parameter int PROG_CYC = NV_WRITE_CYC,
  parameter logic [WIPER_W-1:0] NV_INIT = NV_INIT_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [SLOT_W-1:0] rd_slot,
  output logic [WIPER_W-1:0] rd_d0,
  output logic [WIPER_W-1:0] rd_d1,
  input wire logic wr_req,
  input wire logic [N_POTS-1:0] wr_mask,
  input wire logic [SLOT_W-1:0] wr_slot,
  input wire logic [WIPER_W-1:0] wr_d0,
  input wire logic [WIPER_W-1:0] wr_d1,
  output logic busy
);

  localparam int CW = $clog2(PROG_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(PROG_CYC - 1);

  // not cleared by rst: contents survive like non-volatile cells
  logic [WIPER_W-1:0] mem_r [2**NV_AW] = '{default: NV_INIT};
  logic busy_r, busy_nxt, done;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [N_POTS-1:0] mask_r, mask_nxt;
  logic [SLOT_W-1:0] slot_r, slot_nxt;
  logic [WIPER_W-1:0] d0_r, d0_nxt, d1_r, d1_nxt;

  assign rd_d0 = mem_r[{1'b0, rd_slot}];
  assign rd_d1 = mem_r[{1'b1, rd_slot}];
  assign busy = busy_r;
  assign done = busy_r && (cnt_r == LAST);

  always_comb begin
    busy_nxt = busy_r;
    cnt_nxt = cnt_r;
    mask_nxt = mask_r;
    slot_nxt = slot_r;
    d0_nxt = d0_r;
    d1_nxt = d1_r;
    if (busy_r) begin
      cnt_nxt = cnt_r + CW'(1);
      if (done) begin
        busy_nxt = 1'b0;
        cnt_nxt = '0;
      end
    end else if (wr_req) begin
      busy_nxt = 1'b1;
      mask_nxt = wr_mask;
      slot_nxt = wr_slot;
      d0_nxt = wr_d0;
      d1_nxt = wr_d1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_r <= 1'b0;
      cnt_r <= '0;
      mask_r <= '0;
      slot_r <= '0;
      d0_r <= WIPER_RST;
      d1_r <= WIPER_RST;
    end else begin
      busy_r <= busy_nxt;
      cnt_r <= cnt_nxt;
      mask_r <= mask_nxt;
      slot_r <= slot_nxt;
      d0_r <= d0_nxt;
      d1_r <= d1_nxt;
    end
  end

  // cells change only at the end of the programming time
  always_ff @(posedge clk) begin
    if (!rst && done && mask_r[0]) mem_r[{1'b0, slot_r}] <= d0_r;
    if (!rst && done && mask_r[1]) mem_r[{1'b1, slot_r}] <= d1_r;
  end

  prog_time_a: assert property (@(posedge clk) disable iff (rst)
    busy_r && cnt_r == LAST |=> !busy_r)
    else $error("programming ran past its time");

endmodule

//--- src/dws_top.sv
// command decoder and wiper registers for two 64 tap potentiometers
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
module dws_top
  import dws_pkg::*;
#(
  parameter logic [3:0] TYPE_CODE = TYPE_CODE_DEF,
  parameter int PROG_CYC = NV_WRITE_CYC,
  parameter logic [WIPER_W-1:0] NV_INIT = NV_INIT_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic [1:0] addr_select_pins,
  output logic so,
  output logic so_oe,
  output logic [N_POTS-1:0][N_TAPS-1:0] wiper_tap,
  output logic write_pending_flag
);

  dws_link_if lnk ();

  dws_state_t state_r, state_nxt;
  logic [1:0] addr_meta_r, addr_sync_r;
  logic [7:0] instr_r, instr_nxt;
  logic [N_POTS-1:0][WIPER_W-1:0] wiper_position_reg, wiper_nxt;
  logic [N_POTS-1:0][N_TAPS-1:0] tap_r, tap_nxt;
  logic pend_r, pend_nxt;
  logic [N_POTS-1:0] pmask_r, pmask_nxt;
  logic [SLOT_W-1:0] pslot_r, pslot_nxt;
  logic [N_POTS-1:0][WIPER_W-1:0] pdata_r, pdata_nxt;
  logic [SLOT_W-1:0] rd_slot;
  logic [WIPER_W-1:0] rd_d0, rd_d1, rd_sel;
  logic nv_busy, nv_ok, wr_req;
  logic [3:0] op_in, op_r;
  logic pot_in, pot_r;
  logic [SLOT_W-1:0] slot_in, slot_r;
  logic [7:0] tx_byte;
  logic tx_load;

  ////////////////////////////////////////////////////////////////////////
  // submodules

  dws_spi_rx u_rx (
    .clk(clk),
    .rst(rst),
    .sck(sck),
    .cs_n(cs_n),
    .si(si),
    .so(so),
    .so_oe(so_oe),
    .lnk(lnk.rx)
  );

  dws_nv_store #(
    .PROG_CYC(PROG_CYC),
    .NV_INIT(NV_INIT)
  ) u_nv (
    .clk(clk),
    .rst(rst),
    .rd_slot(rd_slot),
    .rd_d0(rd_d0),
    .rd_d1(rd_d1),
    .wr_req(wr_req),
    .wr_mask(pmask_r),
    .wr_slot(pslot_r),
    .wr_d0(pdata_r[0]),
    .wr_d1(pdata_r[1]),
    .busy(nv_busy)
  );

  ////////////////////////////////////////////////////////////////////////
  // address pins: strapped or driven, so synchronise

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_meta_r <= 2'h0;
      addr_sync_r <= 2'h0;
    end else begin
      addr_meta_r <= addr_select_pins;
      addr_sync_r <= addr_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // field decode

  assign op_in = lnk.byte_data[OP_MSB:OP_LSB];
  assign slot_in = lnk.byte_data[SLOT_SEL_HI:SLOT_SEL_LO];
  assign pot_in = lnk.byte_data[POT_BIT];
  assign op_r = instr_r[OP_MSB:OP_LSB];
  assign slot_r = instr_r[SLOT_SEL_HI:SLOT_SEL_LO];
  assign pot_r = instr_r[POT_BIT];

  always_comb begin
    if (state_r == ST_BOOT) rd_slot = '0;
    else if (state_r == ST_INSTR) rd_slot = slot_in;
    else rd_slot = slot_r;
  end
  assign rd_sel = pot_in ? rd_d1 : rd_d0;

  // a second saved write is dropped while the first is pending or being programmed
  assign nv_ok = !nv_busy && !pend_r;
  assign write_pending_flag = nv_busy;
  assign lnk.tx_load = tx_load;
  assign lnk.tx_byte = tx_byte;

  ////////////////////////////////////////////////////////////////////////
  // command sequencer

  always_comb begin
    state_nxt = state_r;
    instr_nxt = instr_r;
    wiper_nxt = wiper_position_reg;
    pend_nxt = pend_r;
    pmask_nxt = pmask_r;
    pslot_nxt = pslot_r;
    pdata_nxt = pdata_r;
    tx_load = 1'b0;
    tx_byte = 8'h00;
    wr_req = 1'b0;
    case (state_r)
      ST_BOOT: begin
        wiper_nxt[0] = rd_d0;
        wiper_nxt[1] = rd_d1;
        state_nxt = ST_ADDR;
      end
      ST_ADDR: begin
        if (lnk.byte_vld) begin
          if (lnk.byte_data[TYPE_MSB:TYPE_LSB] != TYPE_CODE) begin
            state_nxt = ST_SKIP;
          end else if (lnk.byte_data[ADDR_MSB:ADDR_LSB] != addr_sync_r) begin
            state_nxt = ST_SKIP;
          end else begin
            state_nxt = ST_INSTR;
          end
        end
      end
      ST_INSTR: begin
        if (lnk.byte_vld) begin
          instr_nxt = lnk.byte_data;
          state_nxt = ST_SKIP;
          case (op_in)
            OP_RD_WIPER: begin
              tx_load = 1'b1;
              tx_byte = {2'b00, wiper_position_reg[pot_in]};
            end
            OP_WR_WIPER: state_nxt = ST_DATA;
            OP_RD_SLOT: begin
              tx_load = 1'b1;
              tx_byte = {2'b00, rd_sel};
            end
            OP_WR_SLOT: begin
              if (nv_ok) state_nxt = ST_DATA;
            end
            OP_SLOT_TO_WIPER: wiper_nxt[pot_in] = rd_sel;
            OP_WIPER_TO_SLOT: begin
              if (nv_ok) begin
                pend_nxt = 1'b1;
                pmask_nxt = pot_in ? 2'h2 : 2'h1;
                pslot_nxt = slot_in;
                pdata_nxt = wiper_position_reg;
              end
            end
            OP_ALL_SLOT_TO_WIPER: begin
              wiper_nxt[0] = rd_d0;
              wiper_nxt[1] = rd_d1;
            end
            OP_ALL_WIPER_TO_SLOT: begin
              if (nv_ok) begin
                pend_nxt = 1'b1;
                pmask_nxt = 2'h3;
                pslot_nxt = slot_in;
                pdata_nxt = wiper_position_reg;
              end
            end
            OP_STEP: state_nxt = ST_STEP;
            OP_RD_STATUS: begin
              tx_load = 1'b1;
              tx_byte = 8'h00;
              tx_byte[PEND_BIT] = nv_busy;
            end
            default: state_nxt = ST_SKIP;
          endcase
        end
      end
      ST_DATA: begin
        if (lnk.byte_vld) begin
          state_nxt = ST_SKIP;
          if (op_r == OP_WR_WIPER) begin
            wiper_nxt[pot_r] = lnk.byte_data[WIPER_W-1:0];
          end else begin
            pend_nxt = 1'b1;
            pmask_nxt = pot_r ? 2'h2 : 2'h1;
            pslot_nxt = slot_r;
            pdata_nxt[pot_r] = lnk.byte_data[WIPER_W-1:0];
          end
        end
      end
      ST_STEP: begin
        // saturate at the chain ends rather than wrapping round
        if (lnk.sck_rise) begin
          if (lnk.si_lvl && wiper_position_reg[pot_r] != WIPER_MAX) begin
            wiper_nxt[pot_r] = wiper_position_reg[pot_r] + WIPER_ONE;
          end else if (!lnk.si_lvl && wiper_position_reg[pot_r] != '0) begin
            wiper_nxt[pot_r] = wiper_position_reg[pot_r] - WIPER_ONE;
          end
        end
      end
      default: ;
    endcase
    if (lnk.frame_end && state_r != ST_BOOT) begin
      state_nxt = ST_ADDR;
      wr_req = pend_r;
      pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_BOOT;
      instr_r <= 8'h00;
      wiper_position_reg <= '0;
      pend_r <= 1'b0;
      pmask_r <= '0;
      pslot_r <= '0;
      pdata_r <= '0;
    end else begin
      state_r <= state_nxt;
      instr_r <= instr_nxt;
      wiper_position_reg <= wiper_nxt;
      pend_r <= pend_nxt;
      pmask_r <= pmask_nxt;
      pslot_r <= pslot_nxt;
      pdata_r <= pdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // tap decode: registered from the next wiper value, so it changes on the same edge as the register, far inside both limits

  for (genvar p = 0; p < N_POTS; p++) begin : g_tap
    assign tap_nxt[p] = TAP_ONE << wiper_nxt[p];
  end

  always_ff @(posedge clk) begin
    if (rst) tap_r <= {N_POTS{TAP_ONE}};
    else tap_r <= tap_nxt;
  end
  assign wiper_tap = tap_r;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  type_check_a: assert property (
    state_r == ST_ADDR && lnk.byte_vld &&
    lnk.byte_data[TYPE_MSB:TYPE_LSB] != TYPE_CODE |=> state_r == ST_SKIP)
    else $error("wrong type code accepted");

  addr_check_a: assert property (
    state_r == ST_ADDR && lnk.byte_vld &&
    lnk.byte_data[ADDR_MSB:ADDR_LSB] != addr_sync_r |=> state_r == ST_SKIP)
    else $error("wrong address accepted");

  only_addressed_a: assert property (
    $changed(wiper_position_reg) |->
    $past(state_r) inside {ST_BOOT, ST_INSTR, ST_DATA, ST_STEP})
    else $error("wiper changed outside an addressed frame");

  wiper_write_a: assert property (
    state_r == ST_DATA && lnk.byte_vld && op_r == OP_WR_WIPER |=>
    wiper_position_reg[$past(pot_r)] == $past(lnk.byte_data[WIPER_W-1:0]))
    else $error("wiper write lost");

  slot_load_a: assert property (
    state_r == ST_INSTR && lnk.byte_vld && op_in == OP_SLOT_TO_WIPER &&
    !pot_in |=> wiper_position_reg[0] == $past(rd_d0) &&
    $stable(wiper_position_reg[1]))
    else $error("slot to wiper transfer wrong");

  step_up_a: assert property (
    state_r == ST_STEP && lnk.sck_rise && lnk.si_lvl && !pot_r &&
    wiper_position_reg[0] != WIPER_MAX |=>
    wiper_position_reg[0] == WIPER_W'($past(wiper_position_reg[0]) + 1))
    else $error("step up wrong");

  boot_load_a: assert property (
    state_r == ST_BOOT |=> wiper_position_reg[0] == $past(rd_d0) &&
    wiper_position_reg[1] == $past(rd_d1) && state_r == ST_ADDR)
    else $error("power-up recall wrong");

  volatile_a: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> state_r == ST_BOOT)
    else $error("reset did not restart recall");

  tap_onehot_a: assert property (
    $onehot(tap_r[0]) && $onehot(tap_r[1]))
    else $error("tap decode not one-hot");

  tap_follow_a: assert property (
    $changed(wiper_position_reg[1]) |=>
    tap_r[1] == (TAP_ONE << $past(wiper_position_reg[1])))
    else $error("tap late after load");

  pend_start_a: assert property (
    lnk.frame_end && pend_r && state_r != ST_BOOT |=> write_pending_flag)
    else $error("programming did not start at deselect");

  abandon_a: assert property (
    lnk.frame_end && state_r != ST_BOOT |=> state_r == ST_ADDR)
    else $error("deselect did not restart frame");

endmodule

//--- verification/dws_host_model.sv
// serial master model standing in for the host processor
`timescale 1ns/10ps
module dws_host_model #(
  parameter int HALF_NS = 40,
  parameter int PWRUP_NS = 1000000
) (
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic wait_pwrup();
    #(PWRUP_NS);
  endtask
  // n bits msb first; a count off a byte boundary models an aborted frame
  task automatic frame(input logic [31:0] d, input int n,
                       output logic [31:0] q);
    q = '0;
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si = d[i];
      #(HALF_NS) sck = 1'b1;
      q = {q[30:0], so};
      #(HALF_NS) sck = 1'b0;
    end
    #(HALF_NS) cs_n = 1'b1;
    // released data line must not keep its last level
    si = ~si;
    #(5 * HALF_NS);
  endtask
endmodule

//--- verification/dws_top_tb.sv
// self-checking bench for the dual wiper serial controller
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  mismatches++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end end
module dws_top_tb;
  import dws_pkg::*;
  // short programming time keeps the run brief
  localparam int PROG = 1000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] addr = 2'h0;
  logic sck, cs_n, si, so, so_oe, pend;
  logic [N_POTS-1:0][N_TAPS-1:0] tap;
  logic [WIPER_W-1:0] ex_w [N_POTS];
  logic [WIPER_W-1:0] ex_s [N_POTS][N_SLOTS];
  logic [7:0] hdr;
  logic [31:0] q;
  int mismatches = 0;
  int tests_run = 0;
  int seed = 56200;
  // cycles with the data output enabled, compared across a frame
  int oe_cyc = 0;

  always #4 clk = ~clk;
  always @(posedge clk) if (so_oe === 1'b1) oe_cyc <= oe_cyc + 1;

  dws_top #(.PROG_CYC(PROG)) uut (.clk(clk), .rst(rst), .sck(sck),
    .cs_n(cs_n), .si(si), .addr_select_pins(addr), .so(so),
    .so_oe(so_oe), .wiper_tap(tap), .write_pending_flag(pend));
  dws_host_model #(.PWRUP_NS(2000)) host (.sck(sck), .cs_n(cs_n),
    .si(si), .so(so));
  ////////////////////////////////////////////////////////////////////////
  task automatic cmd(input logic [3:0] op, input logic [1:0] s,
                     input logic p, input logic [7:0] d, input int n);
    logic [31:0] w;
    w = {8'h00, hdr, op, s, 1'b0, p, d};
    // pins move just after a clock edge, never on it
    @(posedge clk);
    #1 host.frame(w >> (24 - n), n, q);
  endtask

  task automatic rd(input logic [3:0] op, input logic [1:0] s,
                    input logic p, input logic [5:0] e);
    int n0;
    n0 = oe_cyc;
    cmd(op, s, p, 8'h00, 24);
    `CHK("read_byte", {2'b00, e}, q[7:0])
    `CHK("read_oe", 1'b1, oe_cyc > n0)
    `CHK("oe_release", 1'b0, so_oe)
  endtask

  task automatic chk_taps();
    repeat (4) @(posedge clk);
    #1;
    foreach (ex_w[i]) `CHK("wiper_tap", TAP_ONE << ex_w[i], tap[i])
  endtask

  task automatic wait_prog();
    int i;
    `CHK("pend_start", 1'b1, pend)
    i = 0;
    while (pend === 1'b1 && i < PROG + 50) begin
      @(posedge clk);
      #1 i++;
    end
    `CHK("pend_end", 1'b0, pend)
  endtask

  function automatic logic [5:0] step_exp(logic [5:0] w, logic [7:0] pat);
    for (int i = 7; i >= 0; i--)
      if (pat[i]) w = (w == WIPER_MAX) ? w : w + WIPER_ONE;
      else w = (w == WIPER_RST) ? w : w - WIPER_ONE;
    return w;
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #(600000);
    mismatches++;
    $display("watchdog expired");
    results();
  end

  initial begin
    logic [5:0] v;
    logic [7:0] pat;
    int p;
    addr = 2'($random(seed));
    hdr = {TYPE_CODE_DEF, 2'b00, addr};
    foreach (ex_s[i, j]) ex_s[i][j] = NV_INIT_DEF;
    foreach (ex_w[i]) ex_w[i] = NV_INIT_DEF;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    host.wait_pwrup();
    chk_taps();
    $display("test recall done");
    for (int i = 0; i < N_POTS; i++) begin
      v = 6'($random(seed));
      cmd(OP_WR_WIPER, 2'h0, i[0], {2'b00, v}, 24);
      ex_w[i] = v;
      rd(OP_RD_WIPER, 2'h0, i[0], v);
    end
    chk_taps();
    $display("test wiper write done");
    for (int i = 0; i < N_POTS * N_SLOTS; i++) begin
      v = 6'($random(seed));
      cmd(OP_WR_SLOT, i[1:0], i[2], {2'b00, v}, 24);
      ex_s[i[2]][i[1:0]] = v;
      cmd(OP_RD_STATUS, 2'h0, 1'b1, 8'h00, 24);
      `CHK("status", 1'b1, q[PEND_BIT])
      // a second write while busy must be dropped
      if (i == 0)
        cmd(OP_WR_SLOT, 2'h0, 1'b0, {2'b00, ~v}, 24);
      wait_prog();
      rd(OP_RD_SLOT, i[1:0], i[2], v);
    end
    $display("test slot write done");
    for (int s = 0; s < N_SLOTS; s++) begin
      p = $random(seed) & 1;
      cmd(OP_SLOT_TO_WIPER, s[1:0], p[0], 8'h00, 16);
      ex_w[p] = ex_s[p][s];
      chk_taps();
    end
    v = 6'($random(seed));
    cmd(OP_WR_WIPER, 2'h0, 1'b1, {2'b00, v}, 24);
    cmd(OP_WIPER_TO_SLOT, 2'h2, 1'b1, 8'h00, 16);
    ex_w[1] = v;
    ex_s[1][2] = v;
    wait_prog();
    rd(OP_RD_SLOT, 2'h2, 1'b1, v);
    cmd(OP_ALL_WIPER_TO_SLOT, 2'h3, 1'b0, 8'h00, 16);
    wait_prog();
    cmd(OP_ALL_SLOT_TO_WIPER, 2'h1, 1'b0, 8'h00, 16);
    foreach (ex_w[i]) begin
      ex_s[i][3] = ex_w[i];
      ex_w[i] = ex_s[i][1];
      rd(OP_RD_SLOT, 2'h3, i[0], ex_s[i][3]);
    end
    chk_taps();
    $display("test transfers done");
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 6'h3D : (i == 1) ? 6'h02 : 6'($random(seed));
      pat = (i == 0) ? 8'hF0 : (i == 1) ? 8'h0F : 8'($random(seed));
      cmd(OP_WR_WIPER, 2'h0, i[0], {2'b00, v}, 24);
      cmd(OP_STEP, 2'h0, i[0], pat, 24);
      ex_w[i[0]] = step_exp(v, pat);
      chk_taps();
    end
    $display("test step done");
    v = ~ex_w[0];
    hdr = {TYPE_CODE_DEF ^ 4'h5, 2'b00, addr};
    cmd(OP_WR_WIPER, 2'h0, 1'b0, {2'b00, v}, 24);
    hdr = {TYPE_CODE_DEF, 2'b00, addr ^ 2'h1};
    cmd(OP_WR_WIPER, 2'h0, 1'b0, {2'b00, v}, 24);
    // an unaddressed device must never drive the data line
    p = oe_cyc;
    cmd(OP_RD_WIPER, 2'h0, 1'b0, 8'h00, 24);
    `CHK("unaddressed_oe", 0, oe_cyc - p)
    hdr = {TYPE_CODE_DEF, 2'b00, addr};
    cmd(OP_WR_WIPER, 2'h0, 1'b0, {2'b00, v}, 20);
    chk_taps();
    @(posedge clk);
    #1 addr = addr + 2'h1;
    hdr = {TYPE_CODE_DEF, 2'b00, addr};
    repeat (4) @(posedge clk);
    cmd(OP_WR_WIPER, 2'h0, 1'b0, {2'b00, v}, 24);
    ex_w[0] = v;
    chk_taps();
    $display("test address and abort done");
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    foreach (ex_w[i]) ex_w[i] = ex_s[i][0];
    chk_taps();
    $display("test second reset done");
    results();
  end
endmodule
